// ---- rtl/vic_core.sv ----
`timescale 1ns/10ps
`default_nettype none
module vic_core
   import vic_pkg::*;
#(
   parameter int STACK_DEPTH = VIC_STACK_DEPTH
) (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   input wire logic mcyc_en,
   input wire logic instr_done,
   input wire logic [2:0] instr_op,
   input wire logic [VIC_PC_W-1:0] ret_pc,
   input wire logic [VIC_DP_W-1:0] cur_dp,
   input wire logic cur_carry,
   input wire logic cur_skip,
   input wire logic [VIC_NIB_W-1:0] cur_a,
   input wire logic [VIC_NIB_W-1:0] cur_b,
   input wire logic ext_edge_evt,
   input wire logic tmr_a_evt,
   input wire logic tmr_b_evt,
   output logic irq_take_o,
   output logic [VIC_PC_W-1:0] irq_vector_o,
   output logic resume_o,
   output logic [VIC_PC_W-1:0] resume_pc_o,
   output logic [VIC_DP_W-1:0] saved_dp_o,
   output logic saved_carry_o,
   output logic saved_skip_o,
   output logic [VIC_NIB_W-1:0] saved_a_o,
   output logic [VIC_NIB_W-1:0] saved_b_o,
   output logic test_skip_o,
   output logic global_irq_gate_o
);

   // ------------------------------------------------------------
   // Helpers
   // ------------------------------------------------------------
   // Highest priority pending source as a one-hot mask
   function automatic logic [VIC_NSRC-1:0] pick_src(input logic [VIC_NSRC-1:0] pend);
      logic [VIC_NSRC-1:0] r;
      r = '0;
      if (pend[VIC_SRC_EXT]) begin
         r[VIC_SRC_EXT] = 1'b1;
      end else if (pend[VIC_SRC_TMR_A]) begin
         r[VIC_SRC_TMR_A] = 1'b1;
      end else if (pend[VIC_SRC_TMR_B]) begin
         r[VIC_SRC_TMR_B] = 1'b1;
      end
      return r;
   endfunction : pick_src

   // Vector of a one-hot source mask
   function automatic logic [VIC_PC_W-1:0] src_vec(input logic [VIC_NSRC-1:0] sel);
      logic [VIC_PC_W-1:0] v;
      v = VIC_VEC_EXT;
      if (sel[VIC_SRC_TMR_A]) begin
         v = VIC_VEC_TMR_A;
      end else if (sel[VIC_SRC_TMR_B]) begin
         v = VIC_VEC_TMR_B;
      end
      return v;
   endfunction : src_vec

   // ------------------------------------------------------------
   // State
   // ------------------------------------------------------------
   logic [3:0] ctrl_q;
   logic [VIC_NSRC-1:0] flag_q;
   logic gate_q;
   logic hold_q;
   vic_state_t state_q;
   logic [VIC_NSRC-1:0] src_q;
   logic [VIC_PC_W-1:0] stack_q [STACK_DEPTH];
   logic [VIC_SP_W-1:0] sp_q;
   logic [VIC_NSRC-1:0] en_vec;
   logic [VIC_NSRC-1:0] evt_vec;
   logic [VIC_NSRC-1:0] pend;
   logic [VIC_NSRC-1:0] test_hit;
   logic [VIC_NSRC-1:0] take_clr;
   logic cond;
   logic wb_req;
   logic taking;
   logic returning;
   logic [VIC_SP_W-1:0] sp_dec;

   assign en_vec = {ctrl_q[VIC_TMR_B_EN_BIT], ctrl_q[VIC_TMR_A_EN_BIT], ctrl_q[VIC_EXT_EN_BIT]};
   assign evt_vec = {tmr_b_evt, tmr_a_evt, ext_edge_evt};
   // all three conditions; hold keeps the gate shut one instruction
   assign pend = flag_q & en_vec;
   assign cond = gate_q & ~hold_q & (|pend);
   assign wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
   assign taking = (state_q == VIC_ST_ENTRY);
   assign returning = instr_done & (instr_op == VIC_OP_RETURN);
   assign sp_dec = sp_q - 3'h1;

   // a test is honoured only when its source is disabled
   always_comb begin
      test_hit = '0;
      if (instr_done) begin
         test_hit[VIC_SRC_EXT] = (instr_op == VIC_OP_TEST_EXT);
         test_hit[VIC_SRC_TMR_A] = (instr_op == VIC_OP_TEST_TMR_A);
         test_hit[VIC_SRC_TMR_B] = (instr_op == VIC_OP_TEST_TMR_B);
      end
      test_hit = test_hit & ~en_vec & flag_q;
      take_clr = taking ? src_q : '0;
   end

   // ------------------------------------------------------------
   // Wishbone slave
   // ------------------------------------------------------------
   // One wait state, registered ack; ack drops the cycle after so no request is seen twice
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h0000_0000;
      end else begin
         wb_ack_o <= wb_req;
         wb_dat_o <= 32'h0000_0000;
         if (wb_req && !wb_we_i) begin
            case (wb_adr_i)
               VIC_CTRL_OFS: wb_dat_o <= {28'h000_0000, ctrl_q};
               VIC_STAT_OFS: wb_dat_o <= {26'h000_0000, hold_q, gate_q, 1'b0, flag_q};
               VIC_CTX_OFS: wb_dat_o <= {13'h0000, saved_skip_o, saved_carry_o, saved_dp_o,
                                         saved_b_o, saved_a_o};
               VIC_STK_OFS: wb_dat_o <= {29'h0000_0000, sp_q};
               default: wb_dat_o <= 32'h0000_0000;
            endcase
         end
      end
   end

   // control resets to zero, spare bit stores writes
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         ctrl_q <= VIC_CTRL_RST;
      end else if (wb_req && wb_we_i && wb_sel_i[0] && wb_adr_i == VIC_CTRL_OFS) begin
         ctrl_q <= wb_dat_i[3:0];
      end
   end

   // ------------------------------------------------------------
   // Request flags
   // ------------------------------------------------------------
   // events set flags; set beats any clear in the same cycle
   // cleared by take or honoured test
   // only the served source is cleared
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         flag_q <= '0;
      end else begin
         flag_q <= (flag_q & ~take_clr & ~test_hit) | evt_vec;
      end
   end

   // skip result reported for one cycle
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         test_skip_o <= 1'b0;
      end else begin
         test_skip_o <= |test_hit;
      end
   end

   // ------------------------------------------------------------
   // Global gate
   // ------------------------------------------------------------
   // on and off instructions steer the gate
   // hold masks the gate until one more instruction completes
   // the return after an on instruction clears hold, so entry can
   // only follow once control is back in the main routine
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         gate_q <= 1'b0;
         hold_q <= 1'b0;
      end else if (taking) begin
         gate_q <= 1'b0;
         hold_q <= 1'b0;
      end else if (instr_done) begin
         case (instr_op)
            VIC_OP_IRQ_ON: begin
               gate_q <= 1'b1;
               hold_q <= 1'b1;
            end
            VIC_OP_IRQ_OFF: begin
               gate_q <= 1'b0;
               hold_q <= 1'b0;
            end
            default: hold_q <= 1'b0;
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         global_irq_gate_o <= 1'b0;
      end else begin
         global_irq_gate_o <= gate_q & ~hold_q & ~taking;
      end
   end

   // ------------------------------------------------------------
   // Entry sequencer
   // ------------------------------------------------------------
   // condition seen at a machine-cycle end, taken at the next
   // instruction end, so one-cycle code gives two cycles, longer gives three
   // a flag left pending is taken as soon as the block lifts
   // priority chosen at the instruction boundary
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         state_q <= VIC_ST_IDLE;
         src_q <= '0;
      end else begin
         case (state_q)
            VIC_ST_IDLE: begin
               if (mcyc_en && cond) begin
                  state_q <= VIC_ST_SEEN;
               end
            end
            VIC_ST_SEEN: begin
               if (!cond) begin
                  state_q <= VIC_ST_IDLE;
               end else if (mcyc_en && instr_done && instr_op != VIC_OP_IRQ_OFF) begin
                  state_q <= VIC_ST_ENTRY;
                  src_q <= pick_src(pend);
               end
            end
            VIC_ST_ENTRY: state_q <= VIC_ST_IDLE;
            default: state_q <= VIC_ST_IDLE;
         endcase
      end
   end

   // page one vector loaded with the take pulse
   // context captured in the same cycle, before the vector runs
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         irq_take_o <= 1'b0;
         irq_vector_o <= VIC_PAGE1_BASE;
      end else begin
         irq_take_o <= taking;
         if (taking) begin
            irq_vector_o <= src_vec(src_q);
         end
      end
   end

   // the pending skip travels with it
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         saved_dp_o <= '0;
         saved_carry_o <= 1'b0;
         saved_skip_o <= 1'b0;
         saved_a_o <= '0;
         saved_b_o <= '0;
      end else if (taking) begin
         saved_dp_o <= cur_dp;
         saved_carry_o <= cur_carry;
         saved_skip_o <= cur_skip;
         saved_a_o <= cur_a;
         saved_b_o <= cur_b;
      end
   end

   // ------------------------------------------------------------
   // Return address stack
   // ------------------------------------------------------------
   // push on entry; overflow wraps and destroys the oldest entry
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         sp_q <= '0;
      end else if (taking) begin
         sp_q <= sp_q + 3'h1;
      end else if (returning) begin
         sp_q <= sp_dec;
      end
   end

   always_ff @(posedge clk) begin
      if (taking) begin
         stack_q[sp_q] <= ret_pc;
      end
   end

   // return pops and resumes; saved context is on the outputs
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         resume_o <= 1'b0;
         resume_pc_o <= '0;
      end else begin
         resume_o <= returning & ~taking;
         if (returning && !taking) begin
            resume_pc_o <= stack_q[sp_dec];
         end
      end
   end

   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst);

   take_needs_cond_a: assert property (
      $rose(irq_take_o) |-> $past(state_q, 2) == VIC_ST_SEEN && $past(cond, 2))
      else $error("interrupt taken without all three conditions");

   vector_match_a: assert property (
      irq_take_o |-> irq_vector_o == src_vec($past(src_q)))
      else $error("vector does not match served source");

   gate_on_a: assert property (
      instr_done && instr_op == VIC_OP_IRQ_ON && !taking |=> gate_q && hold_q)
      else $error("on instruction did not set the gate");

   gate_clear_a: assert property (
      taking |=> !gate_q ##1 !global_irq_gate_o)
      else $error("gate not cleared on entry");

   test_blocked_a: assert property (
      instr_done && instr_op == VIC_OP_TEST_EXT && ctrl_q[VIC_EXT_EN_BIT] |=> !test_skip_o)
      else $error("test honoured for an enabled source");

   flag_set_a: assert property (
      ext_edge_evt |=> flag_q[VIC_SRC_EXT])
      else $error("event did not set flag");

   flag_hold_a: assert property (
      flag_q[VIC_SRC_TMR_A] && !take_clr[VIC_SRC_TMR_A] && !test_hit[VIC_SRC_TMR_A]
      |=> flag_q[VIC_SRC_TMR_A])
      else $error("flag lost without a clear condition");

   prio_order_a: assert property (
      state_q == VIC_ST_SEEN && mcyc_en && instr_done && instr_op != VIC_OP_IRQ_OFF && cond
      && pend[VIC_SRC_EXT] |=> src_q == 3'b001)
      else $error("external source not served first");

   only_served_a: assert property (
      taking && src_q[VIC_SRC_TMR_A] && flag_q[VIC_SRC_EXT] |=> flag_q[VIC_SRC_EXT])
      else $error("other pending flag cleared on entry");

   ctx_saved_a: assert property (
      taking |=> saved_a_o == $past(cur_a) && saved_skip_o == $past(cur_skip))
      else $error("context not saved on entry");

   hold_one_a: assert property (
      hold_q && !instr_done |-> ##1 (state_q != VIC_ST_ENTRY) && !global_irq_gate_o)
      else $error("interrupt enabled before next instruction completed");

   // Address pushed onto an empty stack; a pop back to empty must return it
   logic [VIC_PC_W-1:0] base_push_q;
   always_ff @(posedge clk) begin
      if (taking && sp_q == 3'h0) begin
         base_push_q <= ret_pc;
      end
   end

   ret_pop_a: assert property (
      returning && !taking && sp_q == 3'h1 |=> resume_pc_o == $past(base_push_q))
      else $error("return did not resume at pushed address");

endmodule : vic_core
`default_nettype wire

// ---- common/vic_pkg.sv ----
`default_nettype none
package vic_pkg;
   // ------------------------------------------------------------
   // Widths
   // ------------------------------------------------------------
   localparam int VIC_PC_W = 13;
   localparam int VIC_DP_W = 9;
   localparam int VIC_NIB_W = 4;
   localparam int VIC_NSRC = 3;
   localparam int VIC_STACK_DEPTH = 8;
   localparam int VIC_SP_W = 3;

   // ------------------------------------------------------------
   // Register map, byte addresses on the bus
   // ------------------------------------------------------------
   localparam logic [7:0] VIC_CTRL_OFS = 8'h00;
   localparam logic [7:0] VIC_STAT_OFS = 8'h04;
   localparam logic [7:0] VIC_CTX_OFS = 8'h08;
   localparam logic [7:0] VIC_STK_OFS = 8'h0c;

   // Control register fields and reset value
   localparam int VIC_EXT_EN_BIT = 0;
   localparam int VIC_SPARE_BIT = 1;
   localparam int VIC_TMR_A_EN_BIT = 2;
   localparam int VIC_TMR_B_EN_BIT = 3;
   localparam logic [3:0] VIC_CTRL_RST = 4'h0;

   // Status register fields
   localparam int VIC_STAT_FLAG_LSB = 0;
   localparam int VIC_STAT_GATE_BIT = 4;
   localparam int VIC_STAT_HOLD_BIT = 5;

   // ------------------------------------------------------------
   // Vectors in page 1 and entry latency in machine cycles
   // ------------------------------------------------------------
   localparam logic [VIC_PC_W-1:0] VIC_PAGE1_BASE = 13'h0080;
   localparam logic [VIC_PC_W-1:0] VIC_VEC_EXT = 13'h0080;
   localparam logic [VIC_PC_W-1:0] VIC_VEC_TMR_A = 13'h0084;
   localparam logic [VIC_PC_W-1:0] VIC_VEC_TMR_B = 13'h0086;
   localparam int VIC_LAT_MIN_MCYC = 2;
   localparam int VIC_LAT_MAX_MCYC = 3;

   // Source indices, also the priority order
   localparam int VIC_SRC_EXT = 0;
   localparam int VIC_SRC_TMR_A = 1;
   localparam int VIC_SRC_TMR_B = 2;

   // Completed instruction codes reported by the sequencer
   typedef enum logic [2:0] {
      VIC_OP_NONE = 3'h0,
      VIC_OP_IRQ_ON = 3'h1,
      VIC_OP_IRQ_OFF = 3'h2,
      VIC_OP_RETURN = 3'h3,
      VIC_OP_TEST_EXT = 3'h4,
      VIC_OP_TEST_TMR_A = 3'h5,
      VIC_OP_TEST_TMR_B = 3'h6
   } vic_op_t;

   // Entry sequencer, Gray along idle, seen, entry
   typedef enum logic [1:0] {
      VIC_ST_IDLE = 2'b00,
      VIC_ST_SEEN = 2'b01,
      VIC_ST_ENTRY = 2'b11
   } vic_state_t;
endpackage : vic_pkg
`default_nettype wire

// ---- sim/vic_seq_model.sv ----
`timescale 1ns/10ps
`default_nettype none
// Sequencer stand-in: one machine cycle every two clocks, no-op fill when idle
module vic_seq_model
   import vic_pkg::*;
(
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic req,
   input wire logic [2:0] req_op,
   input wire logic [1:0] req_len,
   input wire logic irq_take,
   input wire logic [VIC_PC_W-1:0] irq_vec,
   input wire logic resume,
   input wire logic [VIC_PC_W-1:0] resume_pc,
   output logic busy,
   output logic mcyc_en,
   output logic instr_done,
   output logic [2:0] instr_op,
   output logic [VIC_PC_W-1:0] pc
);
   logic [1:0] left_q;
   logic [2:0] op_q;
   logic ph_q;

   // Strobes; the code is only meaningful at a boundary
   assign mcyc_en = ph_q;
   assign instr_done = ph_q && (left_q == 2'h0);
   assign instr_op = instr_done ? op_q : 3'h0;

   // A queued request starts only at a boundary, so instructions never overlap
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         ph_q <= 1'b0;
         left_q <= 2'h0;
         op_q <= 3'h0;
         busy <= 1'b0;
      end else begin
         ph_q <= !ph_q;
         if (instr_done) begin
            busy <= req;
            op_q <= req ? req_op : 3'h0;
            left_q <= req ? req_len : 2'h0;
         end else if (ph_q) begin
            left_q <= left_q - 2'h1;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         pc <= 13'h0100;
      end else if (irq_take) begin
         pc <= irq_vec;
      end else if (resume) begin
         pc <= resume_pc;
      end else if (instr_done) begin
         pc <= pc + 13'h0001;
      end
   end
endmodule : vic_seq_model
`default_nettype wire

// ---- sim/tb.sv ----
`timescale 1ns/10ps
`default_nettype none
module tb
   import vic_pkg::*;
();
   logic clk = 1'b0;
   logic sys_rst = 1'b1;
   logic cyc = 1'b0;
   logic we = 1'b0;
   logic [7:0] adr = 8'h00;
   logic [31:0] wdat = 32'h0;
   logic req = 1'b0;
   logic [2:0] rop = 3'h0;
   logic [1:0] rlen = 2'h0;
   logic [2:0] evt = 3'h0;
   logic [31:0] rdat;
   logic ack, busy, mcyc, done, take, res, skip, gate, s_cy, s_sk;
   logic [2:0] op;
   logic [VIC_PC_W-1:0] pc, pc_d1, vec, rpc, take_pc;
   logic [VIC_DP_W-1:0] s_dp;
   logic [3:0] s_a, s_b;
   int n_errors = 0;
   int cmp_count = 0;
   int n_take = 0;
   int n_res = 0;
   int n_skip = 0;

   vic_core dut_u (.clk(clk), .sys_rst(sys_rst), .wb_cyc_i(cyc), .wb_stb_i(cyc),
      .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'h1), .wb_dat_i(wdat), .wb_dat_o(rdat),
      .wb_ack_o(ack), .mcyc_en(mcyc), .instr_done(done), .instr_op(op), .ret_pc(pc),
      .cur_dp(pc[8:0]), .cur_carry(pc[0]), .cur_skip(pc[1]), .cur_a(pc[3:0]),
      .cur_b(pc[7:4]), .ext_edge_evt(evt[0]), .tmr_a_evt(evt[1]), .tmr_b_evt(evt[2]),
      .irq_take_o(take), .irq_vector_o(vec), .resume_o(res), .resume_pc_o(rpc),
      .saved_dp_o(s_dp), .saved_carry_o(s_cy), .saved_skip_o(s_sk), .saved_a_o(s_a),
      .saved_b_o(s_b), .test_skip_o(skip), .global_irq_gate_o(gate));

   vic_seq_model seq_u (.clk(clk), .sys_rst(sys_rst), .req(req), .req_op(rop),
      .req_len(rlen), .irq_take(take), .irq_vec(vec), .resume(res), .resume_pc(rpc),
      .busy(busy), .mcyc_en(mcyc), .instr_done(done), .instr_op(op), .pc(pc));

   // 40 MHz clock
   initial begin
      forever #12.5 clk = ~clk;
   end

   // Count pulses; context is sampled in the entry cycle, one edge before the pulse
   always @(posedge clk) begin
      pc_d1 <= pc;
      if (take === 1'b1) begin
         n_take <= n_take + 1;
         take_pc <= pc_d1;
      end
      if (res === 1'b1) n_res <= n_res + 1;
      if (skip === 1'b1) n_skip <= n_skip + 1;
   end

   // ------------------------------------------------------------
   // Shared tasks
   // ------------------------------------------------------------
   task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         n_errors++;
         $display("unexpected %s exp %h got %h", nm, exp, got);
      end
   endtask : chk

   task automatic stop_test();
      $display("compares %0d mismatches %0d", cmp_count, n_errors);
      if (n_errors == 0 && cmp_count > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask : stop_test

   // Classic single cycle; the request stands until ack is sampled
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q);
      int n;
      n = 0;
      @(posedge clk);
      cyc <= 1'b1;
      we <= w;
      adr <= a;
      wdat <= d;
      do begin
         @(posedge clk);
         n++;
      end while (ack !== 1'b1 && n < 20);
      q = rdat;
      chk("wb_ack", {31'h0, ack}, 32'h1);
      cyc <= 1'b0;
   endtask : wb

   // One instruction of l+1 machine cycles; returns one edge after its boundary
   task automatic exec(input logic [2:0] o, input logic [1:0] l);
      int n;
      n = 0;
      @(posedge clk);
      req <= 1'b1;
      rop <= o;
      rlen <= l;
      do begin
         @(posedge clk);
         n++;
      end while (busy !== 1'b1 && n < 40);
      req <= 1'b0;
      do begin
         @(posedge clk);
         n++;
      end while (busy !== 1'b0 && n < 80);
   endtask : exec

   // Two one-cycle instructions with no filler between them
   task automatic exec_pair(input logic [2:0] o1, input logic [2:0] o2);
      int n;
      n = 0;
      @(posedge clk);
      req <= 1'b1;
      rop <= o1;
      rlen <= 2'h0;
      do begin
         @(posedge clk);
         n++;
      end while (busy !== 1'b1 && n < 40);
      // Second code is picked up at the first one's boundary
      rop <= o2;
      @(posedge clk);
      req <= 1'b0;
      do begin
         @(posedge clk);
         n++;
      end while (busy !== 1'b0 && n < 80);
   endtask : exec_pair

   task automatic pulse(input int s);
      @(posedge clk);
      evt[s] <= 1'b1;
      @(posedge clk);
      evt <= 3'h0;
   endtask : pulse

   task automatic st_chk(input logic [2:0] f);
      logic [31:0] q;
      wb(1'b0, VIC_STAT_OFS, 32'h0, q);
      chk("flags", {29'h0, q[2:0]}, {29'h0, f});
   endtask : st_chk

   task automatic wait_take(input logic [VIC_PC_W-1:0] v, input logic [2:0] f);
      int k;
      int n;
      logic [18:0] e;
      k = n_take;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (n_take == k && n < 60);
      e = {take_pc[0], take_pc[1], take_pc[8:0], take_pc[7:4], take_pc[3:0]};
      chk("take", n_take, k + 1);
      chk("vector", {19'h0, vec}, {19'h0, v});
      chk("context", {13'h0, s_cy, s_sk, s_dp, s_b, s_a}, {13'h0, e});
      chk("gate", {31'h0, gate}, 32'h0);
      st_chk(f);
   endtask : wait_take

   // ------------------------------------------------------------
   // Scenarios
   // ------------------------------------------------------------
   task automatic t_regs();
      logic [31:0] q;
      wb(1'b0, VIC_CTRL_OFS, 32'h0, q);
      chk("ctrl_rst", q, 32'h0);
      wb(1'b1, VIC_CTRL_OFS, 32'h2, q);
      wb(1'b0, VIC_CTRL_OFS, 32'h0, q);
      chk("ctrl_spare", q, 32'h2);
      wb(1'b1, VIC_STAT_OFS, 32'h1f, q);
      st_chk(3'h0);
      wb(1'b0, 8'h40, 32'h0, q);
      chk("unmapped", q, 32'h0);
      wb(1'b1, VIC_CTRL_OFS, 32'h0, q);
      $display("test regs done");
   endtask : t_regs

   // Disabled source: test skips and clears; enabled source: test ignored
   task automatic t_skip();
      logic [31:0] q;
      int k;
      for (int s = 0; s < 3; s++) begin
         k = n_skip;
         pulse(s);
         st_chk(3'h1 << s);
         exec(3'(4 + s), 2'h0);
         st_chk(3'h0);
         chk("skip", n_skip, k + 1);
         wb(1'b1, VIC_CTRL_OFS, 32'h1 << (s == 0 ? 0 : s + 1), q);
         pulse(s);
         exec(3'(4 + s), 2'h0);
         st_chk(3'h1 << s);
         chk("no_skip", n_skip, k + 1);
         wb(1'b1, VIC_CTRL_OFS, 32'h0, q);
         exec(3'(4 + s), 2'h0);
         st_chk(3'h0);
      end
      $display("test skip done");
   endtask : t_skip

   // All three pending; served in order, re-enable just before return
   task automatic t_prio();
      logic [31:0] q;
      int t0;
      int k;
      t0 = n_take;
      wb(1'b1, VIC_CTRL_OFS, 32'hd, q);
      for (int s = 0; s < 3; s++) pulse(s);
      exec(VIC_OP_NONE, 2'h1);
      chk("blocked", n_take, t0);
      st_chk(3'h7);
      exec(VIC_OP_IRQ_ON, 2'h0);
      // Gate output would already be up here if the hold were missing
      @(posedge clk);
      chk("gate_hold", {31'h0, gate}, 32'h0);
      wait_take(VIC_VEC_EXT, 3'h6);
      for (int i = 1; i < 3; i++) begin
         k = n_res;
         exec_pair(VIC_OP_IRQ_ON, VIC_OP_RETURN);
         repeat (3) @(posedge clk);
         chk("resume", n_res, k + 1);
         chk("resume_pc", {19'h0, rpc}, {19'h0, take_pc});
         chk("in_handler", n_take, t0 + i);
         wait_take(i == 1 ? VIC_VEC_TMR_A : VIC_VEC_TMR_B, i == 1 ? 3'h4 : 3'h0);
      end
      exec(VIC_OP_RETURN, 2'h0);
      wb(1'b1, VIC_CTRL_OFS, 32'h0, q);
      $display("test priority done");
   endtask : t_prio

   // Off after a request arrives with the gate on: the pending request must never be taken
   task automatic t_off();
      logic [31:0] q;
      int k;
      k = n_take;
      wb(1'b1, VIC_CTRL_OFS, 32'h1, q);
      exec(VIC_OP_IRQ_ON, 2'h0);
      exec(VIC_OP_NONE, 2'h0);
      @(posedge clk);
      chk("gate_on", {31'h0, gate}, 32'h1);
      pulse(0);
      exec(VIC_OP_IRQ_OFF, 2'h0);
      repeat (16) @(posedge clk);
      chk("off_take", n_take, k);
      chk("off_gate", {31'h0, gate}, 32'h0);
      st_chk(3'h1);
      wb(1'b1, VIC_CTRL_OFS, 32'h0, q);
      exec(VIC_OP_TEST_EXT, 2'h0);
      st_chk(3'h0);
      $display("test off done");
   endtask : t_off

   // Main sequence
   initial begin
      repeat (20) @(posedge clk);
      sys_rst <= 1'b0;
      t_regs();
      t_skip();
      t_prio();
      t_off();
      stop_test();
   end

   // Whole run is a few hundred cycles; this only cuts a hang short
   initial begin
      #(25 * 20000);
      n_errors++;
      stop_test();
   end
endmodule : tb
`default_nettype wire
